//--- rtl/cbi_cpu_end.sv
// cbi_cpu_end: processor bus and control sequencer (no instruction set)
// assumes: a system end answers strobes through cbi_if in the same clock
// Summary of operation
// - one state per clock enable tick
// - machine cycles of three or four states, plus any wait states
// - keep program, stack and index registers
// - refresh low seven bits count per fetch and per interrupt acknowledge
// - page register forms mode-two pointer high byte
// - mode zero after reset acknowledges, drops bus byte
// - mode one pushes and jumps to 0038
// - mode two calls through page and the byte taken at the end of acknowledge T3
// - no interrupt taken while bus granted
// - tri-state address, refresh address on low lines
// - eight-bit tri-state bidirectional data bus
// - fetch marker low during opcode fetch
// - memory request for access and refresh
// - io plus marker means interrupt acknowledge
// - read strobe inputs, write strobe outputs
// - refresh strobe with refresh address, request
// - halt output, nop refresh, leave on interrupt
// - wait stalls, no refresh while waiting
// - maskable request taken after current instruction
// - nmi edge jumps 0066, beats maskable
// - hold request floats buses at fetch T1; an nmi taken at fetch end is served first
// - grant low while buses floated
`default_nettype none
module cbi_cpu_end #(
  parameter int STATE_DIV = 41 // 100 MHz / 2.45 MHz, rounded
) (
  input wire logic clk, // 100 MHz
  input wire logic reset_n, // async, active low
  output logic [15:0] pcOut, // program counter view
  output logic [1:0] irqMode, // current interrupt mode
  cbi_if.cpu pins // processor pins
);
  typedef enum logic [2:0] {
    ST_T1 = 3'b000, ST_T2 = 3'b001, ST_TW = 3'b011, ST_T3 = 3'b010,
    ST_T4 = 3'b110, ST_HOLD = 3'b111
  } cbi_st_t;
  cbi_st_t st_ff;
  cbi_pkg::cbi_cyc_t cyc_ff;
  logic [5:0] div_ff;
  logic tick;
  logic [15:0] program_counter_ff, stack_pointer_ff, indexX_ff, indexY_ff;
  logic [7:0] refresh_ff, page_ff, opcode_ff;
  logic [1:0] mode_ff;
  logic ie_ff, halt_ff, edPending_ff, nmiReq_ff, nmiPrev_ff;
  logic [1:0] nmiSync_ff, irqSync_ff, holdSync_ff, waitSync_ff;
  logic [2:0] step_ff; // interrupt service sequence step
  logic [1:0] svc_ff; // 0 none, 1 nmi, 2 maskable
  logic [15:0] busAddr_ff;
  logic [7:0] busData_ff;
  localparam logic [6:0] RFSH_LOW_ONE = cbi_pkg::RFSH_LOW_ONE;
  // ****************************************
  // state clock
  // ****************************************
  // one-cycle enable per processor state
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) div_ff <= 6'h00;
    else div_ff <= (div_ff == 6'(STATE_DIV - 1)) ? 6'h00 : div_ff + 6'h01;
  end
  assign tick = (div_ff == 6'(STATE_DIV - 1));
  // the four control inputs from the other party are double sampled; data is taken straight
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nmiSync_ff <= 2'h3; irqSync_ff <= 2'h3; holdSync_ff <= 2'h3; waitSync_ff <= 2'h3;
    end else begin
      nmiSync_ff <= {nmiSync_ff[0], pins.nmiIn_n};
      irqSync_ff <= {irqSync_ff[0], pins.maskable_irq_n};
      holdSync_ff <= {holdSync_ff[0], pins.bus_hold_request_n};
      waitSync_ff <= {waitSync_ff[0], pins.waitIn_n};
    end
  end
  // nmi is edge latched so a short pulse is not missed
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      nmiPrev_ff <= 1'b1; nmiReq_ff <= 1'b0;
    end else begin
      nmiPrev_ff <= nmiSync_ff[1];
      if (nmiPrev_ff & !nmiSync_ff[1]) nmiReq_ff <= 1'b1;
      // dropped as its service starts, else it would be taken again forever
      else if (tick && st_ff == ST_T1 && svc_ff == 2'h1 && step_ff == 3'h1) nmiReq_ff <= 1'b0;
    end
  end
  // ****************************************
  // machine cycle sequencer
  // ****************************************
  wire lastState = (st_ff == ST_T4) | (st_ff == ST_T3 && cyc_ff != cbi_pkg::CYC_FETCH &&
    cyc_ff != cbi_pkg::CYC_INTA);
  wire holdNow = !holdSync_ff[1];
  wire takeNmi = nmiReq_ff;
  wire takeIrq = !irqSync_ff[1] && ie_ff && pins.bus_hold_grant_n;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_ff <= ST_T1; cyc_ff <= cbi_pkg::CYC_FETCH; step_ff <= 3'h0; svc_ff <= 2'h0;
      program_counter_ff <= cbi_pkg::PC_RESET; stack_pointer_ff <= 16'hffff;
      indexX_ff <= 16'h0000; indexY_ff <= 16'h0000;
      refresh_ff <= 8'h00; page_ff <= 8'h00; mode_ff <= cbi_pkg::MODE0; ie_ff <= 1'b0;
      halt_ff <= 1'b0; edPending_ff <= 1'b0; opcode_ff <= 8'h00;
    end else if (tick) begin
      case (st_ff)
        ST_T1: if (holdNow && step_ff == 3'h0 && cyc_ff == cbi_pkg::CYC_FETCH) begin
                 st_ff <= ST_HOLD;
               end else st_ff <= ST_T2;
        ST_T2: st_ff <= waitSync_ff[1] ? ST_T3 : ST_TW;
        ST_TW: if (waitSync_ff[1]) st_ff <= ST_T3;
        ST_HOLD: if (!holdNow) st_ff <= ST_T1;
        ST_T3: begin
          if (cyc_ff == cbi_pkg::CYC_FETCH || cyc_ff == cbi_pkg::CYC_INTA) begin
            st_ff <= ST_T4;
            opcode_ff <= pins.dataIn;
            refresh_ff <= {refresh_ff[7], refresh_ff[6:0] + RFSH_LOW_ONE};
          end else st_ff <= ST_T1;
        end
        ST_T4: st_ff <= ST_T1;
        default: st_ff <= ST_T1;
      endcase
      // decode the few opcodes this sequencer understands, at fetch end
      if (lastState && cyc_ff == cbi_pkg::CYC_FETCH && step_ff == 3'h0) begin
        if (!halt_ff) program_counter_ff <= program_counter_ff + 16'h0001;
        if (edPending_ff) begin
          edPending_ff <= 1'b0;
          if (opcode_ff == cbi_pkg::IM0_OP) mode_ff <= cbi_pkg::MODE0;
          if (opcode_ff == cbi_pkg::IM1_OP) mode_ff <= cbi_pkg::MODE1;
          if (opcode_ff == cbi_pkg::IM2_OP) mode_ff <= cbi_pkg::MODE2;
        end else if (opcode_ff == cbi_pkg::ED_PREFIX) edPending_ff <= 1'b1;
        else if (opcode_ff == cbi_pkg::HALT_OP) halt_ff <= 1'b1;
        else if (opcode_ff == cbi_pkg::EI_OP) ie_ff <= 1'b1;
        else if (opcode_ff == cbi_pkg::DI_OP) ie_ff <= 1'b0;
        // pick a pending interrupt for the next boundary, nmi first
        if (!edPending_ff && takeNmi) begin
          svc_ff <= 2'h1; step_ff <= 3'h1; halt_ff <= 1'b0; ie_ff <= 1'b0;
          cyc_ff <= cbi_pkg::CYC_MEMWR;
        end else if (!edPending_ff && takeIrq) begin
          svc_ff <= 2'h2; step_ff <= 3'h1; halt_ff <= 1'b0; ie_ff <= 1'b0;
          cyc_ff <= cbi_pkg::CYC_INTA;
        end
      end else if (lastState && step_ff != 3'h0) begin
        // service walk: [ack], push hi, push lo, [table lo, table hi]
        case (step_ff)
          3'h1: if (svc_ff == 2'h2 && cyc_ff == cbi_pkg::CYC_INTA) begin
                  if (mode_ff == cbi_pkg::MODE0) begin
                    step_ff <= 3'h0; svc_ff <= 2'h0; cyc_ff <= cbi_pkg::CYC_FETCH;
                  end else cyc_ff <= cbi_pkg::CYC_MEMWR;
                end else begin
                  stack_pointer_ff <= stack_pointer_ff - 16'h0001; step_ff <= 3'h2;
                end
          3'h2: begin
            stack_pointer_ff <= stack_pointer_ff - 16'h0001;
            if (svc_ff == 2'h2 && mode_ff == cbi_pkg::MODE2) begin
              step_ff <= 3'h3; cyc_ff <= cbi_pkg::CYC_MEMRD;
            end else begin
              program_counter_ff <= (svc_ff == 2'h1) ? cbi_pkg::VEC_NMI :
                cbi_pkg::VEC_MODE1;
              step_ff <= 3'h0; svc_ff <= 2'h0; cyc_ff <= cbi_pkg::CYC_FETCH;
            end
          end
          // table bytes taken at the end of T3 while the read strobe stands
          3'h3: begin program_counter_ff[7:0] <= pins.dataIn; step_ff <= 3'h4; end
          3'h4: begin
            program_counter_ff[15:8] <= pins.dataIn;
            step_ff <= 3'h0; svc_ff <= 2'h0; cyc_ff <= cbi_pkg::CYC_FETCH;
          end
          default: step_ff <= 3'h0;
        endcase
      end
    end
  end
  // ****************************************
  // pin drive
  // ****************************************
  logic [15:0] pushAddr;
  always_comb begin
    pushAddr = stack_pointer_ff - 16'h0001;
    busAddr_ff = program_counter_ff;
    busData_ff = 8'h00;
    if (step_ff == 3'h1 && cyc_ff == cbi_pkg::CYC_MEMWR) begin
      busAddr_ff = pushAddr; busData_ff = program_counter_ff[15:8];
    end else if (step_ff == 3'h2) begin
      busAddr_ff = pushAddr; busData_ff = program_counter_ff[7:0];
    // opcode_ff still holds the byte taken at the end of acknowledge T3, after io request has dropped
    end else if (step_ff == 3'h3) busAddr_ff = {page_ff, opcode_ff};
    else if (step_ff == 3'h4) busAddr_ff = {page_ff, opcode_ff} + 16'h0001;
  end
  // control pins decoded from state; refresh in T3/T4 of fetch and acknowledge only
  wire fetchLike = (cyc_ff == cbi_pkg::CYC_FETCH) | (cyc_ff == cbi_pkg::CYC_INTA);
  wire refreshing = fetchLike && (st_ff == ST_T3 || st_ff == ST_T4);
  wire active = (st_ff == ST_T1 || st_ff == ST_T2 || st_ff == ST_TW);
  wire isMem = cyc_ff == cbi_pkg::CYC_FETCH || cyc_ff == cbi_pkg::CYC_MEMRD ||
    cyc_ff == cbi_pkg::CYC_MEMWR;
  wire isRd = cyc_ff == cbi_pkg::CYC_FETCH || cyc_ff == cbi_pkg::CYC_MEMRD ||
    cyc_ff == cbi_pkg::CYC_IORD;
  always_comb begin
    pins.addrOut = refreshing ? {9'h000, refresh_ff[6:0]} : busAddr_ff;
    pins.addrOe = (st_ff != ST_HOLD);
    pins.ctrlOe = (st_ff != ST_HOLD);
    pins.bus_hold_grant_n = (st_ff != ST_HOLD);
    pins.dataOut = busData_ff;
    pins.dataOe = !isRd && cyc_ff != cbi_pkg::CYC_INTA && (st_ff == ST_T2 || st_ff == ST_TW ||
      st_ff == ST_T3) && st_ff != ST_HOLD;
    pins.opcode_fetch_marker_n = !(fetchLike && (active || st_ff == ST_T3) &&
      !refreshing);
    pins.memory_request_n = !((isMem && active && cyc_ff != cbi_pkg::CYC_INTA) || refreshing ||
      (isMem && st_ff == ST_T3 && !fetchLike));
    pins.io_request_n = !(((cyc_ff == cbi_pkg::CYC_IORD || cyc_ff == cbi_pkg::CYC_IOWR) &&
      (active || st_ff == ST_T3)) || (cyc_ff == cbi_pkg::CYC_INTA &&
      (st_ff == ST_T2 || st_ff == ST_TW)));
    pins.readStrobe_n = !(isRd && (st_ff == ST_T2 || st_ff == ST_TW ||
      (st_ff == ST_T3 && !fetchLike)));
    pins.writeStrobe_n = !((cyc_ff == cbi_pkg::CYC_MEMWR || cyc_ff == cbi_pkg::CYC_IOWR) &&
      (st_ff == ST_TW || st_ff == ST_T3));
    pins.refresh_strobe_n = !refreshing;
    pins.haltOut_n = !halt_ff;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin pcOut <= 16'h0000; irqMode <= 2'h0; end
    else begin pcOut <= program_counter_ff; irqMode <= mode_ff; end
  end
endmodule // cbi_cpu_end
`default_nettype wire

//--- rtl/cbi_pkg.sv
// cbi_pkg: shared constants and types for the cpu bus interface ends
// assumes: both ends and the interface import nothing, use cbi_pkg::name
`default_nettype none
package cbi_pkg;
  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;
  localparam logic [15:0] PC_RESET = 16'h0000;
  localparam logic [15:0] VEC_MODE1 = 16'h0038;
  localparam logic [15:0] VEC_NMI = 16'h0066;
  localparam logic [7:0] RST38_OP = 8'hff;
  localparam logic [7:0] HALT_OP = 8'h76;
  localparam logic [7:0] EI_OP = 8'hfb;
  localparam logic [7:0] DI_OP = 8'hf3;
  localparam logic [7:0] IM0_OP = 8'h46;
  localparam logic [7:0] IM1_OP = 8'h56;
  localparam logic [7:0] IM2_OP = 8'h5e;
  localparam logic [7:0] ED_PREFIX = 8'hed;
  localparam logic [6:0] RFSH_LOW_ONE = 7'h01;
  localparam logic [1:0] MODE0 = 2'h0;
  localparam logic [1:0] MODE1 = 2'h1;
  localparam logic [1:0] MODE2 = 2'h2;
  // machine cycle kinds
  typedef enum logic [2:0] {
    CYC_FETCH = 3'h0,
    CYC_MEMRD = 3'h1,
    CYC_MEMWR = 3'h2,
    CYC_IORD = 3'h3,
    CYC_IOWR = 3'h4,
    CYC_INTA = 3'h5
  } cbi_cyc_t;
  // host register offsets (byte addresses on AHB-Lite)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_VECTOR = 8'h08;
  localparam logic [7:0] REG_RDATA = 8'h0c;
  localparam logic [7:0] REG_LASTADDR = 8'h10;
  // ctrl bits
  localparam int CTRL_IRQ = 0;
  localparam int CTRL_NMI = 1;
  localparam int CTRL_HOLD = 2;
  localparam int CTRL_WAIT = 3;
  localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage
`default_nettype wire

//--- rtl/cbi_if.sv
// cbi_if: processor pin bundle between the device end and the system end
// assumes: tri-state buses are resolved from the enables by the bench
`default_nettype none
interface cbi_if;
  logic [15:0] addrOut;
  logic addrOe;
  logic [7:0] dataOut;
  logic dataOe;
  logic [7:0] dataIn;
  logic opcode_fetch_marker_n;
  logic memory_request_n;
  logic io_request_n;
  logic readStrobe_n;
  logic writeStrobe_n;
  logic ctrlOe;
  logic refresh_strobe_n;
  logic haltOut_n;
  logic waitIn_n;
  logic maskable_irq_n;
  logic nmiIn_n;
  logic bus_hold_request_n;
  logic bus_hold_grant_n;
  modport cpu (
    output addrOut, addrOe, dataOut, dataOe, opcode_fetch_marker_n,
    output memory_request_n, io_request_n, readStrobe_n, writeStrobe_n,
    output ctrlOe, refresh_strobe_n, haltOut_n, bus_hold_grant_n,
    input dataIn, waitIn_n, maskable_irq_n, nmiIn_n, bus_hold_request_n
  );
  modport sys (
    input addrOut, addrOe, dataOut, dataOe, opcode_fetch_marker_n,
    input memory_request_n, io_request_n, readStrobe_n, writeStrobe_n,
    input ctrlOe, refresh_strobe_n, haltOut_n, bus_hold_grant_n,
    output dataIn, waitIn_n, maskable_irq_n, nmiIn_n, bus_hold_request_n
  );
endinterface
`default_nettype wire

//--- rtl/cbi_sys_end.sv
// cbi_sys_end: system side; an AHB-Lite slave that lets software answer
// bus cycles, raise interrupts, hold the bus and insert waits
// assumes: one clock shared with the processor end; pins sampled twice
`default_nettype none
module cbi_sys_end (
  input wire logic clk, // 100 MHz
  input wire logic reset_n, // async, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer kind
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // always ready
  output logic hresp, // always okay
  cbi_if.sys pins // processor pins
);
  // ****************************************
  // bus slave
  // ****************************************
  logic [31:0] ctrl_ff;
  logic [7:0] vector_ff;
  logic [7:0] wdata_ff;
  logic [15:0] lastAddr_ff;
  logic [2:0] lastKind_ff;
  logic wrPend_ff;
  logic [7:0] wrAddr_ff;
  logic [31:0] hrdata_ff;
  logic [1:0] grantSync_ff;
  logic [1:0] haltSync_ff;
  logic [1:0] wrSync_ff;
  logic [1:0] rdSync_ff;
  logic [1:0] mreqSync_ff;
  logic [1:0] iorqSync_ff;
  logic [1:0] m1Sync_ff;
  logic [15:0] addrSync0_ff;
  logic [15:0] addrSync_ff;
  logic [7:0] dataSync0_ff;
  logic [7:0] dataSync_ff;
  logic wrPrev_ff;
  logic rdPrev_ff;
  logic [31:0] nxt_hrdata;
  // local names for package constants, declared ahead of every use
  localparam logic [31:0] RD_ZERO = cbi_pkg::RD_ZERO;
  localparam int CTRL_IRQ = cbi_pkg::CTRL_IRQ;
  localparam int CTRL_NMI = cbi_pkg::CTRL_NMI;
  localparam int CTRL_HOLD = cbi_pkg::CTRL_HOLD;
  localparam int CTRL_WAIT = cbi_pkg::CTRL_WAIT;
  wire addrPhase = hsel & hready & htrans[1];
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  // capture the address phase; data lands one cycle later
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wrPend_ff <= 1'b0;
      wrAddr_ff <= 8'h00;
    end else begin
      wrPend_ff <= addrPhase & hwrite;
      wrAddr_ff <= haddr[7:0];
    end
  end
  // writable registers
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_ff <= RD_ZERO;
      vector_ff <= 8'h00;
      wdata_ff <= 8'h00; // a nop, so fetches after reset see a known byte
    end else if (wrPend_ff) begin
      if (wrAddr_ff == cbi_pkg::REG_CTRL) ctrl_ff <= hwdata;
      if (wrAddr_ff == cbi_pkg::REG_VECTOR) vector_ff <= hwdata[7:0];
      if (wrAddr_ff == cbi_pkg::REG_RDATA) wdata_ff <= hwdata[7:0];
    end
  end
  // read mux, registered so data stands in the data phase
  always_comb begin
    nxt_hrdata = RD_ZERO;
    case (haddr[7:0])
      cbi_pkg::REG_CTRL: nxt_hrdata = ctrl_ff;
      cbi_pkg::REG_STATUS: nxt_hrdata = {24'h0, lastKind_ff, haltSync_ff[1],
        grantSync_ff[1], 3'h0};
      cbi_pkg::REG_VECTOR: nxt_hrdata = {24'h0, vector_ff};
      cbi_pkg::REG_RDATA: nxt_hrdata = {24'h0, dataSync_ff};
      cbi_pkg::REG_LASTADDR: nxt_hrdata = {16'h0, lastAddr_ff};
      default: nxt_hrdata = RD_ZERO;
    endcase
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) hrdata_ff <= RD_ZERO;
    else if (addrPhase & ~hwrite) hrdata_ff <= nxt_hrdata;
  end
  // ****************************************
  // pin side
  // ****************************************
  // two-flop samplers on the grant, halt, strobe, request, marker, address and data pins from the processor
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      grantSync_ff <= 2'h3;
      haltSync_ff <= 2'h3;
      wrSync_ff <= 2'h3;
      rdSync_ff <= 2'h3;
      mreqSync_ff <= 2'h3;
      iorqSync_ff <= 2'h3;
      m1Sync_ff <= 2'h3;
      addrSync0_ff <= 16'h0000;
      addrSync_ff <= 16'h0000;
      dataSync0_ff <= 8'h00;
      dataSync_ff <= 8'h00;
    end else begin
      grantSync_ff <= {grantSync_ff[0], pins.bus_hold_grant_n};
      haltSync_ff <= {haltSync_ff[0], pins.haltOut_n};
      wrSync_ff <= {wrSync_ff[0], pins.writeStrobe_n};
      rdSync_ff <= {rdSync_ff[0], pins.readStrobe_n};
      mreqSync_ff <= {mreqSync_ff[0], pins.memory_request_n};
      iorqSync_ff <= {iorqSync_ff[0], pins.io_request_n};
      m1Sync_ff <= {m1Sync_ff[0], pins.opcode_fetch_marker_n};
      addrSync0_ff <= pins.addrOut;
      addrSync_ff <= addrSync0_ff;
      dataSync0_ff <= pins.dataOut;
      dataSync_ff <= dataSync0_ff;
    end
  end
  // log the last strobed cycle for software
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      lastAddr_ff <= 16'h0000;
      lastKind_ff <= 3'h0;
      wrPrev_ff <= 1'b1;
      rdPrev_ff <= 1'b1;
    end else begin
      wrPrev_ff <= wrSync_ff[1];
      rdPrev_ff <= rdSync_ff[1];
      if ((!wrSync_ff[1] & wrPrev_ff) | (!rdSync_ff[1] & rdPrev_ff)) begin
        lastAddr_ff <= addrSync_ff;
        lastKind_ff <= {~m1Sync_ff[1], ~iorqSync_ff[1], ~mreqSync_ff[1]};
      end
    end
  end
  // answer reads with the vector on acknowledge, else the loaded byte
  always_comb begin
    pins.dataIn = (!pins.opcode_fetch_marker_n & !pins.io_request_n) ?
      vector_ff : wdata_ff;
    pins.maskable_irq_n = ~ctrl_ff[CTRL_IRQ];
    pins.nmiIn_n = ~ctrl_ff[CTRL_NMI];
    pins.bus_hold_request_n = ~ctrl_ff[CTRL_HOLD];
    pins.waitIn_n = ~ctrl_ff[CTRL_WAIT];
  end
endmodule // cbi_sys_end
`default_nettype wire

//--- dv/cbi_bus_asserts.sv
// cbi_bus_asserts: pin-level checks on the link between the two ends
// assumes: instantiated in tb beside the cbi_if instance, one clock
`default_nettype none
module cbi_bus_asserts (
  input wire logic clk, // bench clock
  input wire logic reset_n, // async, active low
  input wire logic addrOe, // address drive enable
  input wire logic dataOe, // data drive enable
  input wire logic ctrlOe, // strobe drive enable
  input wire logic opcode_fetch_marker_n, // fetch marker
  input wire logic memory_request_n, // memory request
  input wire logic io_request_n, // io request
  input wire logic readStrobe_n, // read strobe
  input wire logic writeStrobe_n, // write strobe
  input wire logic refresh_strobe_n, // refresh strobe
  input wire logic haltOut_n, // halted
  input wire logic bus_hold_request_n, // hold request
  input wire logic bus_hold_grant_n // hold grant
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ************************************************
  // assertions
  // ************************************************
  a_grant_floats_all: assert property (
      !bus_hold_grant_n |-> !addrOe && !dataOe && !ctrlOe)
    else $error("grant low while a bus is driven");
  a_hold_gets_grant: assert property (
      $fell(bus_hold_request_n) |-> ##[1:200] !bus_hold_grant_n)
    else $error("hold request not granted in time");
  a_hold_release: assert property (
      $rose(bus_hold_request_n) |-> ##[1:200] bus_hold_grant_n)
    else $error("grant not withdrawn after hold ends");
  a_strobes_exclusive: assert property (!(!readStrobe_n && !writeStrobe_n))
    else $error("read and write strobes together");
  a_read_data_in: assert property (!readStrobe_n |-> !dataOe)
    else $error("data bus driven during read");
  a_write_data_out: assert property (!writeStrobe_n |-> dataOe && ctrlOe)
    else $error("write strobe without driven data");
  a_mreq_has_addr: assert property (!memory_request_n |-> addrOe)
    else $error("memory request without address");
  a_ack_not_memory: assert property (
      !io_request_n && !opcode_fetch_marker_n |-> memory_request_n)
    else $error("acknowledge mixed with memory request");
  a_refresh_no_rw: assert property (!refresh_strobe_n |-> readStrobe_n && writeStrobe_n)
    else $error("read or write during refresh");
  a_halt_no_write: assert property (!haltOut_n && !$past(haltOut_n) |-> writeStrobe_n)
    else $error("write while halted");
  // main scenarios reached
  c_hold: cover property (!bus_hold_grant_n);
  c_halt: cover property ($fell(haltOut_n));
  c_refresh: cover property (!refresh_strobe_n && !memory_request_n);
endmodule // cbi_bus_asserts
`default_nettype wire

//--- dv/tb.sv
// tb: drives the system end over AHB-Lite and watches the processor end
// assumes: both ends share clk; system end answers with zero wait
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [15:0] pcOut, p;
  logic [1:0] irqMode;
  int failures = 0;
  int check_count = 0;
  cbi_if pins();
  cbi_cpu_end #(.STATE_DIV(4)) cbi_cpu_end_i (.clk(clk), .reset_n(reset_n), .pcOut(pcOut),
    .irqMode(irqMode), .pins(pins));
  cbi_sys_end cbi_sys_end_i (.clk(clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins));
  cbi_bus_asserts cbi_bus_asserts_i (.clk(clk), .reset_n(reset_n), .addrOe(pins.addrOe),
    .dataOe(pins.dataOe), .ctrlOe(pins.ctrlOe),
    .opcode_fetch_marker_n(pins.opcode_fetch_marker_n),
    .memory_request_n(pins.memory_request_n), .io_request_n(pins.io_request_n),
    .readStrobe_n(pins.readStrobe_n), .writeStrobe_n(pins.writeStrobe_n),
    .refresh_strobe_n(pins.refresh_strobe_n), .haltOut_n(pins.haltOut_n),
    .bus_hold_request_n(pins.bus_hold_request_n), .bus_hold_grant_n(pins.bus_hold_grant_n));
  // ************************************************
  // clock, tasks
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // one single word transfer; waits only on hready, the watchdog bounds it
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] seen);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
  endtask
  // status bit of the system end, zero-extended for the compare task
  function automatic logic [15:0] sbit(input logic [31:0] v, input int b);
    return {15'h0000, v[b]};
  endfunction
  // ************************************************
  // tests
  // ************************************************
  initial begin
    reset_n = 1'b0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = '0;
    void'($urandom(32'h7e6cad0f));
    do_reset();
    chk("pc after reset", cbi_pkg::PC_RESET, pcOut);
    chk("mode after reset", {14'h0, cbi_pkg::MODE0}, {14'h0, irqMode});
    ahb(1'b0, cbi_pkg::REG_STATUS, '0);
    chk("grant idle", 16'h0001, sbit(rd, 3));
    ahb(1'b0, 8'h40, '0);
    chk("unmapped read", 16'h0000, rd[15:0]);
    // random vector byte written, then read back
    p = 16'($urandom_range(0, 255));
    ahb(1'b1, cbi_pkg::REG_VECTOR, {24'h0, p[7:0]});
    ahb(1'b0, cbi_pkg::REG_VECTOR, '0);
    chk("vector readback", p, rd[15:0]);
    $display("test reset done");
    // nop stream advances the program counter
    ahb(1'b1, cbi_pkg::REG_RDATA, 32'h0);
    repeat (200) @(posedge clk);
    chk("pc advanced", 16'h0001, {15'h0, pcOut !== cbi_pkg::PC_RESET});
    $display("test fetch done");
    // wait held for a random span freezes the sequencer
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h8);
    repeat (60) @(posedge clk);
    p = pcOut;
    repeat ($urandom_range(20, 150)) @(posedge clk);
    chk("pc in wait", p, pcOut);
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h0);
    repeat (150) @(posedge clk);
    chk("pc after wait", 16'h0001, {15'h0, pcOut !== p});
    $display("test wait done");
    // bus hold for a random span, grant low, no progress
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h4);
    repeat (100) @(posedge clk);
    ahb(1'b0, cbi_pkg::REG_STATUS, '0);
    chk("grant in hold", 16'h0000, sbit(rd, 3));
    p = pcOut;
    repeat ($urandom_range(20, 150)) @(posedge clk);
    chk("pc in hold", p, pcOut);
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h0);
    repeat (100) @(posedge clk);
    ahb(1'b0, cbi_pkg::REG_STATUS, '0);
    chk("grant released", 16'h0001, sbit(rd, 3));
    $display("test hold done");
    // halt; masked request ignored, nmi edge leaves to 0066
    ahb(1'b1, cbi_pkg::REG_RDATA, {24'h0, cbi_pkg::HALT_OP});
    repeat (200) @(posedge clk);
    ahb(1'b0, cbi_pkg::REG_STATUS, '0);
    chk("halted", 16'h0000, sbit(rd, 4));
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h1);
    repeat (200) @(posedge clk);
    ahb(1'b0, cbi_pkg::REG_STATUS, '0);
    chk("irq while disabled", 16'h0000, sbit(rd, 4));
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h3);
    repeat (300) @(posedge clk);
    ahb(1'b1, cbi_pkg::REG_CTRL, 32'h0);
    chk("nmi page", cbi_pkg::VEC_NMI >> 4, pcOut >> 4);
    $display("test halt done");
    // second reset mid-run
    do_reset();
    chk("pc second reset", cbi_pkg::PC_RESET, pcOut);
    chk("mode second reset", {14'h0, cbi_pkg::MODE0}, {14'h0, irqMode});
    $display("test rereset done");
    tally_and_finish();
  end
  // watchdog, well beyond the fewer than two thousand cycles the tests need
  initial begin
    #300000;
    failures++;
    tally_and_finish();
  end
endmodule // tb
`default_nettype wire
